//--- common/adc_req_pkg.sv
// Shared constants for the converter request and trigger control block
package adc_req_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFF_TRIG = 8'h00;
    localparam logic [7:0] OFF_STC = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_CHAN_BASE = 8'h20;
    localparam logic [7:0] OFF_CHAN_LAST = 8'h3C;
    // ==========================================
    // Field positions
    localparam int SEL0_LSB = 0;
    localparam int SEL1_LSB = 3;
    localparam int SYNC0_BIT = 6;
    localparam int SYNC1_BIT = 7;
    localparam int RSEL_LSB = 0;
    localparam int LCC_LSB = 4;
    localparam int GATE_BIT = 0;
    localparam int EXT_TRIGGER_ENABLE_BIT = 2;
    localparam int CLEAR_VALID_COMMAND_BIT = 4;
    localparam int FLUSH_BIT = 5;
    localparam int SWTRIG_BIT = 6;
    localparam int CEV_BIT = 7;
    localparam int IRQ_EV_BIT = 0;
    localparam int IRQ_SMP_BIT = 1;
    // ==========================================
    // Reset values
    localparam logic [7:0] TRIG_RST = 8'h00;
    localparam logic [7:0] STC_RST = 8'h00;
    localparam logic [1:0] RSEL_RST = 2'h0;
    localparam logic [2:0] LCC_RST = 3'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // ==========================================
    // Timing: sample phase base length in analog clock cycles
    localparam logic [8:0] SAMPLE_BASE = 9'h002;
    localparam int NUM_CHAN = 8;
    // ==========================================
    // Sample phase states
    typedef enum logic [0:0] {
        SMP_IDLE = 1'b0,
        SMP_RUN = 1'b1
    } smp_state_t;
endpackage

//--- rtl/adc_request_trigger_control.sv
// Request-side control of the converter: triggers, channel settings, sample time, queue mode
//
// Behaviour
// - Two 3-bit selectors pick one of eight trigger inputs per source.
// - Per-source sync enable inserts a synchronizing stage, else bypassed.
// - Eight channel registers each pick one of four result registers.
// - Each channel register holds a 3-bit limit check control field.
// - Sample phase lasts two analog cycles plus the sample time value.
// - Gate enable bit drives the sequential source gating line through one flop.
// - With external trigger enable set, a rising edge on trigger path 0 sets event flag only while an entry is valid.
// - Clear-valid clears backup valid if set, else queue stage valid.
// - Flush clears all valid flags and the event flag.
// - Software trigger makes a trigger event; waiting source starts its request.
// - Clear-event command clears the event flag.
// - Reserved bits read zero; software writes zero there.
// - Trigger select and sync register resets to all zeros.
// - Event flag clears automatically when the conversion starts.
// - With external trigger use set, event flag gates the request start.
`timescale 1ns/1ps
`default_nettype none
module adc_request_trigger_control
    import adc_req_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] triggerInput0,
    input wire logic [7:0] triggerInput1,
    input wire logic analogClockTick,
    input wire logic sampleStart,
    input wire logic queueLoad,
    input wire logic abortToBackup,
    input wire logic conversionStarted,
    input wire logic externalTriggerUse,
    output logic gateLine,
    output logic requestTriggerLine0,
    output logic requestTriggerLine1,
    output logic conversionRequest,
    output logic sampleActive,
    output logic [15:0] resultTargetSelect,
    output logic [23:0] limitCheckControl,
    output logic irq
);
    import adc_req_pkg::*;

    // ==========================================
    // Helpers
    function automatic logic pickInput(input logic [7:0] vec, input logic [2:0] sel);
        pickInput = vec[sel];
    endfunction

    function automatic logic hitOffset(input logic [31:0] addr, input logic [7:0] off);
        hitOffset = (addr[31:8] == 24'h000000) && (addr[7:0] == off);
    endfunction

    // ==========================================
    // Registers
    logic [7:0] trigSel_q;
    logic [7:0] sampleTime_q;
    logic gateEnable_q;
    logic extTrigEnable_q;
    logic [1:0] resultSel_q [NUM_CHAN];
    logic [2:0] limitCtl_q [NUM_CHAN];
    logic eventFlag_q;
    logic eventFlag_d;
    logic queueValid_q;
    logic queueValid_d;
    logic backupValid_q;
    logic backupValid_d;
    logic [1:0] irqStat_q;
    logic [1:0] irqStat_d;
    logic [1:0] irqMask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic gate_q;
    logic reqTrig0_q;
    logic reqTrig1_q;
    logic convReq_q;
    logic [15:0] rselOut_q;
    logic [23:0] lccOut_q;
    logic syncA0_q;
    logic syncB0_q;
    logic syncA1_q;
    logic syncB1_q;
    logic prevPath0_q;
    smp_state_t smpState_q;
    smp_state_t smpState_d;
    logic [8:0] smpCount_q;
    logic [8:0] smpCount_d;
    logic smpDone;

    // ==========================================
    // APB decode
    wire logic access = psel && penable && !pready_q;
    wire logic commit = psel && penable && pready_q;
    wire logic wrCommit = commit && pwrite;
    wire logic hitTrig = hitOffset(paddr, OFF_TRIG);
    wire logic hitStc = hitOffset(paddr, OFF_STC);
    wire logic hitMode = hitOffset(paddr, OFF_MODE);
    wire logic hitStat = hitOffset(paddr, OFF_STAT);
    wire logic hitIrqStat = hitOffset(paddr, OFF_IRQ_STAT);
    wire logic hitIrqMask = hitOffset(paddr, OFF_IRQ_MASK);
    wire logic hitChan = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0)
        && (paddr[7:0] >= OFF_CHAN_BASE) && (paddr[7:0] <= OFF_CHAN_LAST);
    wire logic [2:0] chanIdx = paddr[4:2];
    wire logic mapped = hitTrig || hitStc || hitMode || hitStat || hitIrqStat || hitIrqMask || hitChan;

    wire logic modeWrite = wrCommit && hitMode;
    wire logic cmdClearValid = modeWrite && pwdata[CLEAR_VALID_COMMAND_BIT];
    wire logic cmdFlush = modeWrite && pwdata[FLUSH_BIT];
    wire logic cmdSwTrigger = modeWrite && pwdata[SWTRIG_BIT];
    wire logic cmdClearEvent = modeWrite && pwdata[CEV_BIT];

    // ==========================================
    // Trigger paths
    // input selection
    wire logic sel0Raw = pickInput(triggerInput0, trigSel_q[SEL0_LSB +: 3]);
    wire logic sel1Raw = pickInput(triggerInput1, trigSel_q[SEL1_LSB +: 3]);
    wire logic path0 = trigSel_q[SYNC0_BIT] ? syncB0_q : sel0Raw;
    wire logic path1 = trigSel_q[SYNC1_BIT] ? syncB1_q : sel1Raw;
    wire logic anyValid = queueValid_q || backupValid_q;
    // edge only counts with a valid entry
    wire logic hwEvent = extTrigEnable_q && path0 && !prevPath0_q && anyValid;
    // software trigger acts like a detected edge
    wire logic swEvent = cmdSwTrigger && anyValid;
    // event gates the start only when external trigger use is set
    wire logic reqReady = gateEnable_q && anyValid && (!externalTriggerUse || eventFlag_q);

    // two flops, first read only by second
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            syncA0_q <= 1'b0;
            syncB0_q <= 1'b0;
            syncA1_q <= 1'b0;
            syncB1_q <= 1'b0;
            prevPath0_q <= 1'b0;
        end
        else
        begin
            syncA0_q <= sel0Raw;
            syncB0_q <= syncA0_q;
            syncA1_q <= sel1Raw;
            syncB1_q <= syncA1_q;
            prevPath0_q <= path0;
        end
    end

    // ==========================================
    // Event and valid flags; a set in the clearing cycle wins
    always_comb
    begin
        eventFlag_d = eventFlag_q;
        if (cmdClearEvent)
            eventFlag_d = 1'b0;
        if (cmdFlush)
            eventFlag_d = 1'b0;
        if (conversionStarted)
            eventFlag_d = 1'b0;
        if (hwEvent || swEvent)
            eventFlag_d = 1'b1;
    end

    always_comb
    begin
        queueValid_d = queueValid_q;
        backupValid_d = backupValid_q;
        if (cmdClearValid)
        begin
            if (backupValid_q)
                backupValid_d = 1'b0;
            else
                queueValid_d = 1'b0;
        end
        // Started conversion retires the entry it came from
        if (conversionStarted)
        begin
            if (backupValid_q)
                backupValid_d = 1'b0;
            else
                queueValid_d = 1'b0;
        end
        if (cmdFlush)
        begin
            queueValid_d = 1'b0;
            backupValid_d = 1'b0;
        end
        if (queueLoad)
            queueValid_d = 1'b1;
        if (abortToBackup)
            backupValid_d = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            eventFlag_q <= 1'b0;
            queueValid_q <= 1'b0;
            backupValid_q <= 1'b0;
        end
        else
        begin
            eventFlag_q <= eventFlag_d;
            queueValid_q <= queueValid_d;
            backupValid_q <= backupValid_d;
        end
    end

    // ==========================================
    // Sample phase timer, counted in analog clock ticks
    always_comb
    begin
        smpState_d = smpState_q;
        smpCount_d = smpCount_q;
        smpDone = 1'b0;
        case (smpState_q)
            SMP_IDLE:
            begin
                if (sampleStart)
                begin
                    smpState_d = SMP_RUN;
                    smpCount_d = SAMPLE_BASE + {1'b0, sampleTime_q};
                end
            end
            SMP_RUN:
            begin
                if (analogClockTick)
                begin
                    if (smpCount_q == 9'h001)
                    begin
                        smpState_d = SMP_IDLE;
                        smpCount_d = 9'h000;
                        smpDone = 1'b1;
                    end
                    else
                        smpCount_d = smpCount_q - 9'h001;
                end
            end
            default:
            begin
                smpState_d = SMP_IDLE;
                smpCount_d = 9'h000;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            smpState_q <= SMP_IDLE;
            smpCount_q <= 9'h000;
        end
        else
        begin
            smpState_q <= smpState_d;
            smpCount_q <= smpCount_d;
        end
    end

    // ==========================================
    // Interrupt status, write one to clear; set beats clear
    wire logic irqClear = wrCommit && hitIrqStat;
    always_comb
    begin
        irqStat_d = irqStat_q;
        if (irqClear)
            irqStat_d = irqStat_q & ~pwdata[1:0];
        if (eventFlag_d && !eventFlag_q)
            irqStat_d[IRQ_EV_BIT] = 1'b1;
        if (smpDone)
            irqStat_d[IRQ_SMP_BIT] = 1'b1;
    end

    // ==========================================
    // Control registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            trigSel_q <= TRIG_RST;
            sampleTime_q <= STC_RST;
            gateEnable_q <= 1'b0;
            extTrigEnable_q <= 1'b0;
            irqMask_q <= IRQ_RST;
            irqStat_q <= IRQ_RST;
        end
        else
        begin
            irqStat_q <= irqStat_d;
            if (wrCommit && hitTrig)
                trigSel_q <= pwdata[7:0];
            if (wrCommit && hitStc)
                sampleTime_q <= pwdata[7:0];
            if (modeWrite)
            begin
                gateEnable_q <= pwdata[GATE_BIT];
                extTrigEnable_q <= pwdata[EXT_TRIGGER_ENABLE_BIT];
            end
            if (wrCommit && hitIrqMask)
                irqMask_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            if (!rst_n)
            begin
                resultSel_q[i] <= RSEL_RST;
                limitCtl_q[i] <= LCC_RST;
            end
            else if (wrCommit && hitChan && (chanIdx == i[2:0]))
            begin
                resultSel_q[i] <= pwdata[RSEL_LSB +: 2];
                limitCtl_q[i] <= pwdata[LCC_LSB +: 3];
            end
        end
    end

    // ==========================================
    // Read mux; reserved bits and command bits read zero
    logic [31:0] readData;
    always_comb
    begin
        readData = 32'h00000000;
        if (hitTrig)
            readData[7:0] = trigSel_q;
        if (hitStc)
            readData[7:0] = sampleTime_q;
        if (hitMode)
        begin
            readData[GATE_BIT] = gateEnable_q;
            readData[EXT_TRIGGER_ENABLE_BIT] = extTrigEnable_q;
        end
        if (hitStat)
            readData[3:0] = {sampleActive, backupValid_q, queueValid_q, eventFlag_q};
        if (hitIrqStat)
            readData[1:0] = irqStat_q;
        if (hitIrqMask)
            readData[1:0] = irqMask_q;
        if (hitChan)
            readData[7:0] = {1'b0, limitCtl_q[chanIdx], 2'h0, resultSel_q[chanIdx]};
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            // One wait state so that read data comes from a flop
            pready_q <= access;
            pslverr_q <= access && !mapped;
            // Writes answer with zero data so no stale read word rides along
            if (access)
                prdata_q <= pwrite ? 32'h00000000 : readData;
        end
    end

    // ==========================================
    // Registered outputs
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            gate_q <= 1'b0;
            reqTrig0_q <= 1'b0;
            reqTrig1_q <= 1'b0;
            convReq_q <= 1'b0;
            irq_q <= 1'b0;
            rselOut_q <= 16'h0000;
            lccOut_q <= 24'h000000;
        end
        else
        begin
            gate_q <= gateEnable_q;
            reqTrig0_q <= path0;
            reqTrig1_q <= path1;
            convReq_q <= reqReady;
            irq_q <= |(irqStat_d & irqMask_q);
            for (int i = 0; i < NUM_CHAN; i++)
            begin
                rselOut_q[2*i +: 2] <= resultSel_q[i];
                lccOut_q[3*i +: 3] <= limitCtl_q[i];
            end
        end
    end

    assign sampleActive = (smpState_q == SMP_RUN);
    assign gateLine = gate_q;
    assign requestTriggerLine0 = reqTrig0_q;
    assign requestTriggerLine1 = reqTrig1_q;
    assign conversionRequest = convReq_q;
    assign resultTargetSelect = rselOut_q;
    assign limitCheckControl = lccOut_q;
    assign irq = irq_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule // adc_request_trigger_control
`default_nettype wire

//--- bench/adc_req_trig_sva.sv
// Port-level checks for the converter request and trigger control block
`timescale 1ns/1ps
`default_nettype none
module adc_req_trig_sva
    import adc_req_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] triggerInput0,
    input wire logic [7:0] triggerInput1,
    input wire logic analogClockTick,
    input wire logic gateLine,
    input wire logic requestTriggerLine0,
    input wire logic requestTriggerLine1,
    input wire logic conversionRequest,
    input wire logic sampleActive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] trigQ;
    logic [7:0] stcQ;
    logic [7:0] modeQ;
    logic [8:0] tickQ;
    logic wrDone;
    logic rdOk;
    assign wrDone = psel && penable && pready && pwrite && !pslverr;
    assign rdOk = pready && !pwrite && !pslverr;
    // ==========================================
    // Shadow of the trigger, sample time and mode fields
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            trigQ <= 8'h00;
            stcQ <= 8'h00;
            modeQ <= 8'h00;
        end
        else if (wrDone && paddr == {24'h0, OFF_TRIG})
            trigQ <= pwdata[7:0];
        else if (wrDone && paddr == {24'h0, OFF_STC})
            stcQ <= pwdata[7:0];
        else if (wrDone && paddr == {24'h0, OFF_MODE})
            modeQ <= pwdata[7:0] & 8'h05;
    end
    // Ticks seen during one sample phase
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !sampleActive)
            tickQ <= 9'h000;
        else if (analogClockTick)
            tickQ <= tickQ + 9'h001;
    end
    // ==========================================
    // Assertions
    a_pready_single: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_pready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
    a_slverr_qual: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    a_trig_readback: assert property (rdOk && paddr == {24'h0, OFF_TRIG} |-> prdata[7:0] == trigQ)
        else $error("trigger register readback wrong");
    a_mode_readback: assert property (rdOk && paddr == {24'h0, OFF_MODE} |-> prdata[7:0] == modeQ)
        else $error("mode register readback wrong");
    a_bypass_path: assert property (!trigQ[6] |=> requestTriggerLine0 == $past(triggerInput0[trigQ[2:0]]))
        else $error("bypassed trigger path wrong");
    a_sync_path: assert property (trigQ[7] && trigQ == $past(trigQ, 3)
        |-> requestTriggerLine1 == $past(triggerInput1[trigQ[5:3]], 3)) else $error("synced trigger path wrong");
    a_gate_off: assert property (!modeQ[0] [*3] |-> !gateLine && !conversionRequest)
        else $error("gate off but line or request high");
    a_gate_on: assert property (modeQ[0] [*3] |-> gateLine) else $error("gate on but line low");
    a_sample_len: assert property ($fell(sampleActive) |-> tickQ == {1'b0, stcQ} + 9'h002)
        else $error("sample phase length wrong");
    c_write: cover property (wrDone);
    c_sample: cover property ($fell(sampleActive));
    c_request: cover property (conversionRequest);
endmodule // adc_req_trig_sva
bind adc_request_trigger_control adc_req_trig_sva chk_u (.*);
`default_nettype wire

//--- bench/trig_src_model.sv
// Trigger source and analog tick model at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module trig_src_model
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] want0,
    input wire logic [7:0] want1,
    output logic [7:0] triggerInput0,
    output logic [7:0] triggerInput1,
    output logic analogClockTick
);
    logic [1:0] divQ;
    // ==========================================
    // Sources stay low in reset so no stray edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            divQ <= 2'h0;
            triggerInput0 <= 8'h00;
            triggerInput1 <= 8'h00;
        end
        else
        begin
            divQ <= divQ + 2'h1;
            triggerInput0 <= want0;
            triggerInput1 <= want1;
        end
    end
    assign analogClockTick = (divQ == 2'h3);
endmodule // trig_src_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the converter request and trigger control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adc_req_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] want0 = 8'h00;
    logic [7:0] want1 = 8'h00;
    logic sampleStart = 1'b0;
    logic queueLoad = 1'b0;
    logic abortToBackup = 1'b0;
    logic conversionStarted = 1'b0;
    logic externalTriggerUse = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] triggerInput0;
    logic [7:0] triggerInput1;
    logic analogClockTick;
    logic gateLine;
    logic requestTriggerLine0;
    logic requestTriggerLine1;
    logic conversionRequest;
    logic sampleActive;
    logic [15:0] resultTargetSelect;
    logic [23:0] limitCheckControl;
    logic irq;
    logic [31:0] rdat;
    logic slv;
    int chanM[8];
    int trigM, stcM, modeM, maskM, irqS, qv, bv, ev, etu;
    int seed, cycles, nMismatch, compares, i, n, t;
    adc_request_trigger_control dut_u (.*);
    trig_src_model src_u (.*);
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nMismatch++;
            conclude();
        end
    end
    // ==========================================
    // Bus and compare tasks
    task automatic conclude();
        if (nMismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the cycle ceiling ends a wait for the answer
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input int e);
        apb(1'b0, a, 32'h0);
        check(rdat, 32'(e));
    endtask
    // Model view of request, irq and status
    task automatic chk();
        repeat (5) @(posedge ref_clk);
        check(conversionRequest, 32'((modeM & 1) && (qv || bv) && (!etu || ev)));
        check(irq, 32'((irqS & maskM) != 0));
        rd(OFF_STAT, bv * 4 + qv * 2 + ev);
    endtask
    task automatic evSet();
        if ((qv || bv) && !ev)
            irqS |= 1;
        if (qv || bv)
            ev = 1;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        seed = 32'h4A7BA485;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(OFF_TRIG, 0);
        rd(OFF_STC, 0);
        rd(OFF_MODE, 0);
        for (i = 0; i < 8; i++)
        begin
            chanM[i] = $random(seed) & 8'hFF;
            apb(1'b1, OFF_CHAN_BASE + 8'(4 * i), 32'(chanM[i]));
            chanM[i] &= 8'h73;
        end
        for (i = 0; i < 8; i++)
        begin
            rd(OFF_CHAN_BASE + 8'(4 * i), chanM[i]);
            check(resultTargetSelect[2 * i +: 2], chanM[i] & 3);
            check(limitCheckControl[3 * i +: 3], chanM[i] >> 4);
        end
        apb(1'b1, 8'h18, 32'hFFFFFFFF);
        check(slv, 1);
        rd(8'h18, 0);
        for (i = 0; i < 8; i++)
        begin
            trigM = i | ((7 - i) << 3) | ($random(seed) & 8'hC0);
            apb(1'b1, OFF_TRIG, 32'(trigM));
            want0 <= 8'h01 << i;
            want1 <= 8'h80 >> i;
            repeat (6) @(posedge ref_clk);
            check(requestTriggerLine0, 1);
            check(requestTriggerLine1, 1);
            want0 <= 8'h00;
            want1 <= 8'h00;
            rd(OFF_TRIG, trigM);
        end
        maskM = 3;
        apb(1'b1, OFF_IRQ_MASK, 32'h3);
        apb(1'b1, OFF_MODE, 32'hFF);
        modeM = 5;
        rd(OFF_MODE, 5);
        apb(1'b1, OFF_TRIG, 32'h0);
        etu = 1;
        externalTriggerUse <= 1'b1;
        queueLoad <= 1'b1;
        @(posedge ref_clk);
        queueLoad <= 1'b0;
        qv = 1;
        chk();
        want0 <= 8'h01;
        evSet();
        chk();
        want0 <= 8'h00;
        conversionStarted <= 1'b1;
        @(posedge ref_clk);
        conversionStarted <= 1'b0;
        ev = 0;
        qv = 0;
        chk();
        want0 <= 8'h01;
        chk();
        want0 <= 8'h00;
        queueLoad <= 1'b1;
        abortToBackup <= 1'b1;
        @(posedge ref_clk);
        queueLoad <= 1'b0;
        abortToBackup <= 1'b0;
        qv = 1;
        bv = 1;
        apb(1'b1, OFF_MODE, 32'h15);
        bv = 0;
        chk();
        apb(1'b1, OFF_MODE, 32'h15);
        qv = 0;
        chk();
        queueLoad <= 1'b1;
        @(posedge ref_clk);
        queueLoad <= 1'b0;
        qv = 1;
        apb(1'b1, OFF_MODE, 32'h45);
        evSet();
        chk();
        apb(1'b1, OFF_MODE, 32'h85);
        ev = 0;
        chk();
        apb(1'b1, OFF_MODE, 32'h45);
        evSet();
        abortToBackup <= 1'b1;
        @(posedge ref_clk);
        abortToBackup <= 1'b0;
        bv = 1;
        apb(1'b1, OFF_MODE, 32'h25);
        qv = 0;
        bv = 0;
        ev = 0;
        chk();
        apb(1'b1, OFF_IRQ_STAT, 32'h1);
        irqS &= 2;
        rd(OFF_IRQ_STAT, irqS);
        queueLoad <= 1'b1;
        etu = 0;
        externalTriggerUse <= 1'b0;
        @(posedge ref_clk);
        queueLoad <= 1'b0;
        qv = 1;
        apb(1'b1, OFF_MODE, 32'h0);
        modeM = 0;
        chk();
        for (i = 0; i < 3; i++)
        begin
            stcM = $random(seed) & 8'h07;
            apb(1'b1, OFF_STC, 32'(stcM));
            rd(OFF_STC, stcM);
            sampleStart <= 1'b1;
            @(posedge ref_clk);
            sampleStart <= 1'b0;
            n = 0;
            t = 0;
            do
            begin
                @(posedge ref_clk);
                if (sampleActive === 1'b1 && analogClockTick === 1'b1)
                    t++;
                n++;
            end
            while (sampleActive === 1'b1 && n < 3000);
            check(t, stcM + 2);
            irqS |= 2;
            rd(OFF_IRQ_STAT, irqS);
            check(irq, 1);
            apb(1'b1, OFF_IRQ_STAT, 32'h2);
            irqS = 0;
        end
        conclude();
    end
endmodule // testbench
`default_nettype wire
